// [hdl/gov_pkg.sv]
// shared constants for the speed setpoint and gain scheduler
`default_nettype none
package gov_pkg;
	localparam int SPD_W       = 16;             // speed in rpm
	localparam int GAIN_W      = 16;             // gains, Q8.8
	localparam int POS_W       = 16;             // shaft position / fuel demand, 0..FFFF
	localparam int GAIN_FRAC   = 8;
	localparam int STAB_W      = 8;              // stability knob 00..FF, 80 = mid
	localparam int CLK_HZ      = 40_000_000;
	localparam int TICK_PER_S  = 1000;           // setpoint update rate
	localparam int TICK_CYC    = CLK_HZ / TICK_PER_S;
	localparam int NUM_BP      = 5;
	localparam logic [SPD_W-1:0]  SP_RST    = 16'h0000;
	localparam logic [GAIN_W-1:0] GAIN_RST  = 16'h0000;
	localparam logic [GAIN_W-1:0] GAIN_ONE  = 16'h0100;
	localparam logic [STAB_W-1:0] STAB_MID  = 8'h80;
	localparam int DROOP_MAX_PCT = 18;           // full knob droop
	localparam int DROOP_TRAVEL_DEG = 42;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_HOLD_MIN, ST_TRACK} sp_state_t;
endpackage
`default_nettype wire

// [hdl/gov_ramp.sv]
// one ramp step of a value toward a target at a per-tick rate
`timescale 1ns/1ps
`default_nettype none
module gov_ramp
(
	input  wire logic [15:0] cur_in,
	input  wire logic [15:0] tgt_in,
	input  wire logic [15:0] rate_in,
	output logic      [15:0] nxt_out
);
	logic [16:0] up;
	logic [16:0] dn;
	always_comb
	begin
		up = {1'b0, cur_in} + {1'b0, rate_in};
		dn = {1'b0, cur_in} - {1'b0, rate_in};
		if (tgt_in > cur_in)
			nxt_out = (up[16] || up[15:0] > tgt_in) ? tgt_in : up[15:0];
		else if (tgt_in < cur_in)
			nxt_out = (dn[16] || dn[15:0] < tgt_in) ? tgt_in : dn[15:0];
		else
			nxt_out = cur_in;
	end
endmodule // gov_ramp
`default_nettype wire

// [hdl/gov_interp.sv]
// linear interpolation between two points, x clamped to [x0,x1]
`timescale 1ns/1ps
`default_nettype none
module gov_interp
(
	input  wire logic [15:0] x_in,
	input  wire logic [15:0] x0_in,
	input  wire logic [15:0] x1_in,
	input  wire logic [15:0] y0_in,
	input  wire logic [15:0] y1_in,
	output logic      [15:0] y_out
);
	logic [16:0] dx;
	logic [16:0] span;
	logic signed [17:0] dy;
	logic signed [35:0] prod;
	logic signed [35:0] q;
	always_comb
	begin
		dx   = {1'b0, x_in} - {1'b0, x0_in};
		span = {1'b0, x1_in} - {1'b0, x0_in};
		dy   = $signed({2'b00, y1_in}) - $signed({2'b00, y0_in});
		prod = dy * $signed({1'b0, dx});
		q    = (span == 17'h0) ? 36'sh0 : prod / $signed({19'h0, span});
		if (x_in <= x0_in || x1_in <= x0_in)
			y_out = y0_in;
		else if (x_in >= x1_in)
			y_out = y1_in;
		else
			y_out = 16'(y0_in + q[15:0]);
	end
endmodule // gov_interp
`default_nettype wire

// [hdl/gov_sched.sv]
// speed setpoint ramp, droop and pid gain scheduler
`timescale 1ns/1ps
`default_nettype none
// Operation
// - every commanded setpoint change ramps at a rate in rpm per second
// - a full-scale rate (FFFF) makes the change immediate
// - start ramp rate moves setpoint from run speed to start target
// - raise and lower rates set slope while command active
// - remote analog setpoint changes are rate limited
// - at run speed load measured speed then ramp to target
// - rated target: raise or lower halts ramp, then commands are followed
// - halt below minimum limit keeps ramping up to minimum first
// - droop lowers setpoint with shaft travel, knob 0..18% over 42 degrees
// - droop uses no-load, full-load positions and nominal droop
// - zero droop gives isochronous setpoint
// - cold start gain used until speed passes start-gain threshold
// - single gain mode keeps constant proportional gain
// - position curve: five breakpoints on fuel demand, interpolated
// - integral gain interpolates idle at run to rated at rated
// - derivative gain is constant in every mode
// - stability knob multiplier 0.5 to 2, 1.0 at mid, on p and i
// - speed error is measured speed minus setpoint
// - error beyond window multiplies primary gain by ratio
// - ratio of exactly one disables the boost
// - dual gain applies on top of every gain mode
// - lower wins when raise and lower both active
// - analog mode ignores raise and lower
module gov_sched
#(
	parameter int TICK_CYC = gov_pkg::TICK_CYC
)
(
	input  wire logic                               sys_clk_in,
	input  wire logic                               resetn_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          speed_in,
	input  wire logic                               raise_in,
	input  wire logic                               lower_in,
	input  wire logic                               analog_en_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          analog_sp_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          run_speed_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          min_speed_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          rated_speed_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          lo_limit_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          hi_limit_in,
	input  wire logic                               target_rated_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          start_rate_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          raise_rate_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          lower_rate_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          analog_rate_in,
	input  wire logic [gov_pkg::POS_W-1:0]          shaft_pos_in,
	input  wire logic [gov_pkg::POS_W-1:0]          noload_pos_in,
	input  wire logic [gov_pkg::POS_W-1:0]          fullload_pos_in,
	input  wire logic [7:0]                         droop_knob_in,
	input  wire logic [gov_pkg::POS_W-1:0]          fuel_demand_in,
	input  wire logic                               cold_en_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          cold_thr_in,
	input  wire logic [gov_pkg::GAIN_W-1:0]         cold_gain_in,
	input  wire logic                               curve_mode_in,
	input  wire logic [gov_pkg::GAIN_W-1:0]         p_gain_in,
	input  wire logic [gov_pkg::NUM_BP*16-1:0]      curve_x_in,
	input  wire logic [gov_pkg::NUM_BP*16-1:0]      curve_y_in,
	input  wire logic [gov_pkg::GAIN_W-1:0]         i_idle_in,
	input  wire logic [gov_pkg::GAIN_W-1:0]         i_rated_in,
	input  wire logic [gov_pkg::GAIN_W-1:0]         d_gain_in,
	input  wire logic [gov_pkg::STAB_W-1:0]         stab_knob_in,
	input  wire logic [gov_pkg::SPD_W-1:0]          window_in,
	input  wire logic [gov_pkg::GAIN_W-1:0]         ratio_in,
	output logic      [gov_pkg::SPD_W-1:0]          setpoint_out,
	output logic signed [gov_pkg::SPD_W:0]          speed_err_out,
	output logic      [gov_pkg::GAIN_W-1:0]         p_gain_out,
	output logic      [gov_pkg::GAIN_W-1:0]         i_gain_out,
	output logic      [gov_pkg::GAIN_W-1:0]         d_gain_out,
	output logic                                    boost_out,
	output logic                                    in_control_out
);
	// asynchronous pins pass two flops
	logic [2:0] cmd_m_q;
	logic [2:0] cmd_s_q;
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			cmd_m_q <= 3'h0;
			cmd_s_q <= 3'h0;
		end
		else
		begin
			cmd_m_q <= {analog_en_in, lower_in, raise_in};
			cmd_s_q <= cmd_m_q;
		end
	end
	wire        raise_s  = cmd_s_q[0];
	wire        lower_s  = cmd_s_q[1];
	wire        analog_s = cmd_s_q[2];
	// update tick so rates are per second
	logic [31:0] tick_cnt_q;
	logic [31:0] tick_cnt_d;
	logic        tick;
	always_comb
	begin
		tick       = (tick_cnt_q == 32'(TICK_CYC - 1));
		tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
	end
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
			tick_cnt_q <= 32'h0;
		else
			tick_cnt_q <= tick_cnt_d;
	end
	// rate per tick, at least one rpm; full-scale rate jumps to target at once
	function automatic logic [15:0] per_tick(input logic [15:0] r);
		logic [15:0] v;
		v = 16'(r / 16'(gov_pkg::TICK_PER_S));
		return (r == 16'hFFFF) ? 16'hFFFF : ((v == 16'h0000) ? 16'h0001 : v);
	endfunction
	// setpoint state machine
	gov_pkg::sp_state_t st_q;
	gov_pkg::sp_state_t st_d;
	logic [15:0] base_q;
	logic [15:0] base_d;
	logic [15:0] tgt;
	logic [15:0] rate;
	logic [15:0] ramp_nxt;
	logic [15:0] start_tgt;
	logic        cmd_up;
	logic        cmd_dn;
	always_comb
	begin
		start_tgt = target_rated_in ? rated_speed_in : min_speed_in;
		cmd_dn    = lower_s && !analog_s;
		cmd_up    = raise_s && !lower_s && !analog_s;
		st_d      = st_q;
		tgt       = base_q;
		rate      = 16'h0001;
		case (st_q)
			gov_pkg::ST_IDLE:
			begin
				if (speed_in >= run_speed_in)
					st_d = gov_pkg::ST_START;
			end
			gov_pkg::ST_START:
			begin
				tgt  = start_tgt;
				rate = per_tick(start_rate_in);
				if (target_rated_in && (cmd_up || cmd_dn))
					st_d = (base_q < min_speed_in) ? gov_pkg::ST_HOLD_MIN : gov_pkg::ST_TRACK;
				else if (base_q == start_tgt)
					st_d = gov_pkg::ST_TRACK;
			end
			gov_pkg::ST_HOLD_MIN:
			begin
				tgt  = min_speed_in;
				rate = per_tick(start_rate_in);
				if (base_q >= min_speed_in)
					st_d = gov_pkg::ST_TRACK;
			end
			gov_pkg::ST_TRACK:
			begin
				if (analog_s)
				begin
					tgt  = analog_sp_in;
					rate = per_tick(analog_rate_in);
				end
				else if (cmd_dn)
				begin
					tgt  = lo_limit_in;
					rate = per_tick(lower_rate_in);
				end
				else if (cmd_up)
				begin
					tgt  = hi_limit_in;
					rate = per_tick(raise_rate_in);
				end
			end
			default:
				st_d = gov_pkg::ST_IDLE;
		endcase
	end
	gov_ramp u_ramp
	(
		.cur_in  (base_q),
		.tgt_in  (tgt),
		.rate_in (rate),
		.nxt_out (ramp_nxt)
	);
	always_comb
	begin
		base_d = base_q;
		if (st_q == gov_pkg::ST_IDLE)
			base_d = speed_in;
		else if (tick)
			base_d = ramp_nxt;
		if (st_q != gov_pkg::ST_IDLE && base_d < lo_limit_in)
			base_d = lo_limit_in;
		if (st_q != gov_pkg::ST_IDLE && base_d > hi_limit_in)
			base_d = hi_limit_in;
	end
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			st_q   <= gov_pkg::ST_IDLE;
			base_q <= gov_pkg::SP_RST;
		end
		else
		begin
			st_q   <= st_d;
			base_q <= base_d;
		end
	end
	// droop: knob 00..FF maps 0..18% of rated over full travel
	logic [15:0] travel;
	logic [15:0] span;
	logic [47:0] droop_num;
	logic [47:0] droop_rpm;
	logic [15:0] sp_droop;
	always_comb
	begin
		travel = (shaft_pos_in > noload_pos_in) ? 16'(shaft_pos_in - noload_pos_in) : 16'h0000;
		span   = (fullload_pos_in > noload_pos_in) ? 16'(fullload_pos_in - noload_pos_in) : 16'h0001;
		if (travel > span)
			travel = span;
		droop_num = 48'(rated_speed_in) * 48'(droop_knob_in) * 48'(travel) * 48'(gov_pkg::DROOP_MAX_PCT);
		droop_rpm = droop_num / (48'(span) * 48'hFF * 48'h64);
		if (droop_knob_in == 8'h00)
			sp_droop = base_q;
		else if (droop_rpm[15:0] >= base_q || droop_rpm[47:16] != 32'h0)
			sp_droop = 16'h0000;
		else
			sp_droop = 16'(base_q - droop_rpm[15:0]);
	end
	// proportional gain from curve or constant
	logic [15:0] seg_y [gov_pkg::NUM_BP-2:0];
	logic [15:0] curve_gain;
	genvar g;
	generate
		for (g = 0; g < gov_pkg::NUM_BP - 1; g++)
		begin : g_seg
			gov_interp u_seg
			(
				.x_in  (fuel_demand_in),
				.x0_in (curve_x_in[g*16 +: 16]),
				.x1_in (curve_x_in[(g+1)*16 +: 16]),
				.y0_in (curve_y_in[g*16 +: 16]),
				.y1_in (curve_y_in[(g+1)*16 +: 16]),
				.y_out (seg_y[g])
			);
		end
	endgenerate
	always_comb
	begin
		curve_gain = seg_y[0];
		for (int k = 1; k < gov_pkg::NUM_BP - 1; k++)
			if (fuel_demand_in > curve_x_in[k*16 +: 16])
				curve_gain = seg_y[k];
	end
	logic [15:0] i_sched;
	gov_interp u_integ
	(
		.x_in  (speed_in),
		.x0_in (run_speed_in),
		.x1_in (rated_speed_in),
		.y0_in (i_idle_in),
		.y1_in (i_rated_in),
		.y_out (i_sched)
	);
	// error, window, stability and final gains
	logic signed [16:0] err;
	logic [16:0]        err_mag;
	logic               boost;
	logic [15:0]        p_prim;
	logic [15:0]        stab_mul;
	logic [15:0]        p_fin;
	logic [15:0]        i_fin;
	logic               cold_passed_q;
	logic               cold_passed_d;
	function automatic logic [15:0] qmul(input logic [15:0] a, input logic [15:0] b);
		logic [31:0] m;
		m = 32'(a) * 32'(b);
		m = m >> gov_pkg::GAIN_FRAC;
		return (m[31:16] != 16'h0000) ? 16'hFFFF : m[15:0];
	endfunction
	always_comb
	begin
		err     = $signed({1'b0, speed_in}) - $signed({1'b0, sp_droop});
		err_mag = err[16] ? 17'(-err) : 17'(err);
		boost   = (ratio_in != gov_pkg::GAIN_ONE) && (err_mag > {1'b0, window_in});
		cold_passed_d = cold_passed_q || (speed_in > cold_thr_in);
		if (cold_en_in && !cold_passed_q)
			p_prim = cold_gain_in;
		else if (curve_mode_in)
			p_prim = curve_gain;
		else
			p_prim = p_gain_in;
		// knob 00 -> 0.5, 80 -> 1.0, FF -> ~2
		if (stab_knob_in < gov_pkg::STAB_MID)
			stab_mul = 16'h0080 + {8'h00, stab_knob_in};
		else
			stab_mul = 16'h0100 + {7'h00, stab_knob_in - gov_pkg::STAB_MID, 1'b0};
		p_fin = qmul(boost ? qmul(p_prim, ratio_in) : p_prim, stab_mul);
		i_fin = qmul(i_sched, stab_mul);
	end
	always_ff @(posedge sys_clk_in)
	begin
		if (!resetn_in)
		begin
			cold_passed_q  <= 1'b0;
			setpoint_out   <= gov_pkg::SP_RST;
			speed_err_out  <= 17'sh0;
			p_gain_out     <= gov_pkg::GAIN_RST;
			i_gain_out     <= gov_pkg::GAIN_RST;
			d_gain_out     <= gov_pkg::GAIN_RST;
			boost_out      <= 1'b0;
			in_control_out <= 1'b0;
		end
		else
		begin
			cold_passed_q  <= cold_passed_d;
			setpoint_out   <= sp_droop;
			speed_err_out  <= err;
			p_gain_out     <= p_fin;
			i_gain_out     <= i_fin;
			d_gain_out     <= d_gain_in;
			boost_out      <= boost;
			in_control_out <= (st_q != gov_pkg::ST_IDLE);
		end
	end
endmodule // gov_sched
`default_nettype wire

// [bench/gov_sched_assertions.sv]
// concurrent checks on the scheduler ports
`timescale 1ns/1ps
`default_nettype none
module gov_sched_assertions
#(
	parameter int TICK_CYC = 10
)
(
	input wire logic               sys_clk_in,
	input wire logic               resetn_in,
	input wire logic        [15:0] speed_in,
	input wire logic        [15:0] run_speed_in,
	input wire logic        [15:0] rated_speed_in,
	input wire logic        [15:0] lo_limit_in,
	input wire logic        [15:0] hi_limit_in,
	input wire logic        [7:0]  droop_knob_in,
	input wire logic               curve_mode_in,
	input wire logic               cold_en_in,
	input wire logic        [15:0] p_gain_in,
	input wire logic        [15:0] i_idle_in,
	input wire logic        [15:0] i_rated_in,
	input wire logic        [15:0] d_gain_in,
	input wire logic        [7:0]  stab_knob_in,
	input wire logic        [15:0] ratio_in,
	input wire logic        [15:0] setpoint_out,
	input wire logic signed [16:0] speed_err_out,
	input wire logic        [15:0] p_gain_out,
	input wire logic        [15:0] i_gain_out,
	input wire logic        [15:0] d_gain_out,
	input wire logic               boost_out,
	input wire logic               in_control_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	chk_d_gain_const: assert property ($past(resetn_in) |-> d_gain_out == $past(d_gain_in))
		else $error("derivative gain differs");
	chk_ratio_one_off: assert property ($past(resetn_in) && $past(ratio_in) == 16'h0100 |-> !boost_out)
		else $error("boost with unity ratio");
	chk_err_diff: assert property ($past(resetn_in, 2) && droop_knob_in == 8'h00 && $stable(speed_in)
		&& $past(setpoint_out, 2) == setpoint_out
		|-> speed_err_out == $signed({1'b0, speed_in}) - $signed({1'b0, setpoint_out}))
		else $error("speed error wrong");
	chk_sp_clamp: assert property (in_control_out && $past(in_control_out, 2) && droop_knob_in == 8'h00
		|-> setpoint_out >= lo_limit_in && setpoint_out <= hi_limit_in)
		else $error("setpoint outside limits");
	chk_tick_hold: assert property (in_control_out && $past(in_control_out, 3) && $changed(setpoint_out)
		&& droop_knob_in == 8'h00 && $past(droop_knob_in, 2) == 8'h00 && $stable(droop_knob_in)
		|=> ($stable(setpoint_out) || droop_knob_in != 8'h00) [*8])
		else $error("setpoint moved between ticks");
	chk_i_rated: assert property ($past(resetn_in) && $past(speed_in) >= $past(rated_speed_in)
		&& $past(stab_knob_in) == 8'h80 && !boost_out |-> i_gain_out == $past(i_rated_in))
		else $error("integral gain not rated value");
	chk_i_idle: assert property ($past(resetn_in) && $past(speed_in) <= $past(run_speed_in)
		&& $past(stab_knob_in) == 8'h80 && !boost_out |-> i_gain_out == $past(i_idle_in))
		else $error("integral gain not idle value");
	chk_p_single: assert property ($past(resetn_in) && !$past(curve_mode_in) && !$past(cold_en_in)
		&& $past(stab_knob_in) == 8'h80 && !boost_out |-> p_gain_out == $past(p_gain_in))
		else $error("single proportional gain wrong");
	chk_stab_half: assert property ($past(resetn_in) && !$past(curve_mode_in) && !$past(cold_en_in)
		&& $past(stab_knob_in) == 8'h00 && !boost_out |-> p_gain_out == ($past(p_gain_in) >> 1))
		else $error("half stability gain wrong");
	cover property (boost_out);
	cover property ($rose(in_control_out));
	cover property (in_control_out && setpoint_out == hi_limit_in);
endmodule // gov_sched_assertions
bind gov_sched gov_sched_assertions #(.TICK_CYC(TICK_CYC)) i_gov_sched_assertions (.*);
`default_nettype wire

// [bench/gov_engine.sv]
// engine speed model that slews toward a commanded speed
`timescale 1ns/1ps
`default_nettype none
module gov_engine
(
	input  wire logic        sys_clk_in,
	input  wire logic [15:0] tgt_in,
	output var logic  [15:0] speed_out
);
	initial speed_out = 16'h0000;
	always @(posedge sys_clk_in)
	begin
		if (speed_out < tgt_in) speed_out <= speed_out + 16'h0001;
		else if (speed_out > tgt_in) speed_out <= speed_out - 16'h0001;
	end
endmodule // gov_engine
`default_nettype wire

// [bench/gov_sched_tb.sv]
// self-checking bench for the setpoint and gain scheduler
`timescale 1ns/1ps
`default_nettype none
module gov_sched_tb;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [15:0] speed_in, analog_sp_in, run_speed_in, min_speed_in, rated_speed_in, lo_limit_in, hi_limit_in;
	logic [15:0] start_rate_in, raise_rate_in, lower_rate_in, analog_rate_in, shaft_pos_in, noload_pos_in;
	logic [15:0] fullload_pos_in, fuel_demand_in, cold_thr_in, cold_gain_in, p_gain_in, i_idle_in, i_rated_in;
	logic [15:0] d_gain_in, window_in, ratio_in, eng_tgt, sp0, setpoint_out, p_gain_out, i_gain_out, d_gain_out;
	logic raise_in, lower_in, analog_en_in, target_rated_in, cold_en_in, curve_mode_in, boost_out, in_control_out;
	logic [7:0] droop_knob_in, stab_knob_in;
	logic [79:0] curve_x_in, curve_y_in;
	logic signed [16:0] speed_err_out;
	int n_mismatch = 0;
	int num_checks = 0;
	always #12.5 sys_clk_in = ~sys_clk_in;
	gov_sched #(.TICK_CYC(10)) i_gov_sched (.*);
	gov_engine i_gov_engine (.sys_clk_in(sys_clk_in), .tgt_in(eng_tgt), .speed_out(speed_in));
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask
	task automatic near(input logic [15:0] v, input logic [15:0] e, input logic [15:0] t);
		check(17'((v >= e - t && v <= e + t) ? e : v), 17'(e));
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		{raise_in, lower_in, analog_en_in, target_rated_in, curve_mode_in} <= 5'h00;
		cold_en_in <= 1'b1;
		run_speed_in <= 16'h0190;
		min_speed_in <= 16'h0258;
		rated_speed_in <= 16'h03E8;
		lo_limit_in <= 16'h0100;
		hi_limit_in <= 16'h0600;
		start_rate_in <= 16'h2710;
		raise_rate_in <= 16'h03E8;
		lower_rate_in <= 16'h03E8;
		analog_rate_in <= 16'h07D0;
		analog_sp_in <= 16'h0000;
		{shaft_pos_in, noload_pos_in, fullload_pos_in} <= {16'h0000, 16'h0000, 16'h8000};
		{droop_knob_in, stab_knob_in, fuel_demand_in} <= {8'h00, 8'h80, 16'h1800};
		{cold_thr_in, cold_gain_in, p_gain_in} <= {16'h0300, 16'h0080, 16'h0200};
		curve_x_in <= {16'h4000, 16'h3000, 16'h2000, 16'h1000, 16'h0000};
		curve_y_in <= {16'h0500, 16'h0400, 16'h0300, 16'h0200, 16'h0100};
		{i_idle_in, i_rated_in, d_gain_in} <= {16'h0040, 16'h0100, 16'h0020};
		{window_in, ratio_in, eng_tgt} <= {16'h0005, 16'h0100, 16'h0000};
		cyc(8);
		resetn_in <= 1'b1;
		cyc(3);
		check(17'(p_gain_out), 17'h00080);
		eng_tgt <= 16'h01F4;
		repeat (600) if (in_control_out !== 1'b1) @(posedge sys_clk_in);
		cyc(2);
		near(setpoint_out, 16'h0190, 16'h000C);
		check(17'(in_control_out), 17'h00001);
		cyc(400);
		check(17'(setpoint_out), 17'h00258);
		check(17'(i_gain_out), 17'h00060);
		raise_in <= 1'b1;
		cyc(100);
		raise_in <= 1'b0;
		cyc(4);
		near(setpoint_out, 16'h0262, 16'h0002);
		sp0 = setpoint_out;
		{raise_in, lower_in} <= 2'b11;
		cyc(100);
		{raise_in, lower_in} <= 2'b00;
		cyc(4);
		near(setpoint_out, sp0 - 16'h000A, 16'h0002);
		sp0 = setpoint_out;
		{analog_sp_in, analog_en_in, raise_in} <= {16'h0300, 1'b1, 1'b1};
		cyc(100);
		{analog_en_in, raise_in} <= 2'b00;
		cyc(4);
		near(setpoint_out, sp0 + 16'h0014, 16'h0003);
		{raise_rate_in, raise_in} <= {16'hFFFF, 1'b1};
		cyc(300);
		raise_in <= 1'b0;
		check(17'(setpoint_out), 17'h00600);
		{lower_rate_in, lower_in} <= {16'hFFFF, 1'b1};
		cyc(300);
		lower_in <= 1'b0;
		check(17'(setpoint_out), 17'h00100);
		{analog_sp_in, analog_rate_in, analog_en_in} <= {16'h03E8, 16'hFFFF, 1'b1};
		cyc(16);
		check(17'(setpoint_out), 17'h003E8);
		{shaft_pos_in, droop_knob_in} <= {16'h8000, 8'hFF};
		cyc(20);
		near(setpoint_out, 16'h0334, 16'h0001);
		droop_knob_in <= 8'h00;
		cyc(20);
		check(17'(setpoint_out), 17'h003E8);
		eng_tgt <= 16'h044C;
		cyc(800);
		check(17'(p_gain_out), 17'h00200);
		check(17'(i_gain_out), 17'h00100);
		check(17'(boost_out), 17'h00000);
		check(speed_err_out, 17'h00064);
		{stab_knob_in, cold_en_in} <= {8'h00, 1'b0};
		cyc(3);
		check(17'(p_gain_out), 17'h00100);
		stab_knob_in <= 8'hFF;
		cyc(3);
		near(p_gain_out, 16'h0400, 16'h0008);
		{stab_knob_in, curve_mode_in} <= {8'h80, 1'b1};
		cyc(3);
		check(17'(p_gain_out), 17'h00280);
		ratio_in <= 16'h0200;
		cyc(3);
		check(17'(boost_out), 17'h00001);
		check(17'(p_gain_out), 17'h00500);
		curve_mode_in <= 1'b0;
		cyc(3);
		check(17'(p_gain_out), 17'h00400);
		window_in <= 16'hFFFF;
		cyc(3);
		check(17'(boost_out), 17'h00000);
		check(17'(p_gain_out), 17'h00200);
		d_gain_in <= 16'h0030;
		cyc(3);
		check(17'(d_gain_out), 17'h00030);
		eng_tgt <= 16'h012C;
		cyc(900);
		{resetn_in, target_rated_in, analog_en_in} <= 3'b010;
		cyc(8);
		check(17'(in_control_out), 17'h00000);
		{resetn_in, eng_tgt} <= {1'b1, 16'h01F4};
		repeat (600) if (in_control_out !== 1'b1) @(posedge sys_clk_in);
		cyc(5);
		lower_in <= 1'b1;
		cyc(3);
		lower_in <= 1'b0;
		cyc(500);
		near(setpoint_out, 16'h0258, 16'h0001);
		complete_run;
	end
	initial
	begin
		cyc(20000);
		n_mismatch++;
		complete_run;
	end
endmodule // gov_sched_tb
`default_nettype wire
